// >>> verilog/rbf_pkg.sv
/*
  Shared constants and the state record of the dual row character buffer.
  Assumes one system clock; every pin of the buffer is sampled into it.
*/
package rbf_pkg;

  // Bank geometry
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 8;
  localparam int          BANK_DEPTH  = 135;

  // Read clocks from the end flag rising until the data pins float
  localparam logic [1:0]  FLOAT_TICKS = 2'h2;

  // Bit positions of the sampled pin vector
  localparam int          PIN_WCLK    = 0;
  localparam int          PIN_RCLK    = 1;
  localparam int          PIN_WEA     = 2;
  localparam int          PIN_WEB     = 3;
  localparam int          PIN_SWAP    = 4;
  localparam int          PIN_CLR     = 5;
  localparam int          PIN_REN     = 6;
  localparam int          PIN_OE      = 7;
  localparam int          PIN_DATA    = 8;
  localparam int          PIN_W       = PIN_DATA + DATA_W;

  // Positions in the remembered previous levels
  localparam int          PRV_WCLK    = 0;
  localparam int          PRV_RCLK    = 1;
  localparam int          PRV_CLR     = 2;

  // Whole state of the buffer control, registered in one process
  typedef struct packed {
    logic [PIN_W-1:0]  pin_s1;
    logic [PIN_W-1:0]  pin_s2;
    logic [2:0]        prev;
    logic [DATA_W-1:0] hold;
    logic              bank;
    logic              swap_done;
    logic              clr_pend;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] pipe;
    logic [DATA_W-1:0] out;
    logic              wfull;
    logic              rend;
    logic [1:0]        float_cnt;
    logic              oe_n_out;
  } rbf_state_t;

  // Reset: counters at zero, bank 0 read, data pins released
  localparam rbf_state_t RST_STATE = '{
    pin_s1: '0, pin_s2: '0, prev: '0, hold: '0, bank: 1'b0, swap_done: 1'b0,
    clr_pend: 1'b0, waddr: '0, raddr: '0, pipe: '0, out: '0, wfull: 1'b0,
    rend: 1'b0, float_cnt: 2'h0, oe_n_out: 1'b1};

endpackage

// >>> verilog/rbf_row_buffer.sv
/*
  Dual row character buffer: two RAM banks used ping-pong, one filled from
  system memory under the write clock pin while the other is played out to
  the character generator under the read clock pin.
  Assumes clk is far faster than both pin clocks (at least four clk periods
  per pin clock phase); all pins, clocks included, are sampled on clk.
*/
// Summary of operation
// - Two banks of 135 bytes, write and read
// - Latch input byte on each write clock rise
// - Both enables high: store byte, bump address
// - Writing stops on enable low or full bank
// - Swap low, clear low: zero counters, swap banks
// - Read enable high: bank byte into output latch
// - Each read advances read address by one
// - Clear falling edge clears read address once
// - Clear may be tied to read enable
// - Overflow outputs allow chaining several buffers
// - Output valid two read clocks after enable
// - Write flag high at last position; one more write fills bank
// - Read flag high at last position; outputs float later
// - Outputs driven when output enable low
`timescale 1ns/100ps

module rbf_row_buffer
  import rbf_pkg::*;
#(
  parameter int DEPTH = BANK_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              wr_clk_pin,
  input  wire logic              rd_clk_pin,
  input  wire logic [DATA_W-1:0] char_in,
  input  wire logic              wr_enable_a,
  input  wire logic              wr_enable_b,
  input  wire logic              row_swap_n,
  input  wire logic              addr_clear_n,
  input  wire logic              rd_enable,
  input  wire logic              out_enable_n,
  output logic      [DATA_W-1:0] char_out,
  output logic                   char_out_oe_n,
  output logic                   wr_full_flag,
  output logic                   rd_end_flag
);

  // Index of the last storage slot, and the mark a counter parks on once
  // the bank is used up; the counters never pass the mark, so a chained
  // second buffer sees a steady flag instead of a wrapped address
  localparam logic [ADDR_W-1:0] LAST_POS = ADDR_W'(DEPTH - 1);
  localparam logic [ADDR_W-1:0] FILLED   = ADDR_W'(DEPTH);

  // Whole control record and its next value; every output is a field of q
  rbf_state_t        q;
  rbf_state_t        d;
  // Two banks side by side; bank index q.bank is the one being read,
  // the other one is the one being filled
  logic [DATA_W-1:0] mem [2][DEPTH];
  logic [PIN_W-1:0]  pins;
  logic              wr_tick;
  logic              rd_tick;
  logic              clr_fall;
  logic              swap_go;
  logic              clear_now;
  logic              wr_go;
  logic              rd_go;
  logic [DATA_W-1:0] mem_rd;

  // Pins gathered into one vector for the two-stage sampler.
  // Sampling every pin through the same two stages keeps data and enables
  // aligned with the pin clocks, at the cost of about three clk of latency.
  assign pins = {char_in, out_enable_n, rd_enable, addr_clear_n, row_swap_n,
                 wr_enable_b, wr_enable_a, rd_clk_pin, wr_clk_pin};

  // Edges are taken from the second sampler stage only.
  // The first stage may still be settling, so it feeds nothing but stage two.
  // Previous levels reset low, matching the idle level of both pin clocks.
  assign wr_tick  = q.pin_s2[PIN_WCLK] & ~q.prev[PRV_WCLK];
  assign rd_tick  = q.pin_s2[PIN_RCLK] & ~q.prev[PRV_RCLK];
  assign clr_fall = ~q.pin_s2[PIN_CLR] & q.prev[PRV_CLR];

  // Swap once per low phase of the swap pin, else a long low would ping-pong
  assign swap_go = rd_tick & ~q.pin_s2[PIN_SWAP] & ~q.pin_s2[PIN_CLR]
                   & ~q.swap_done;

  // Read address is cleared by a pending clear edge or by a swap
  assign clear_now = rd_tick & (q.clr_pend | swap_go);

  // Write only into the bank not being read, until it is filled.
  // A write that meets a swap is dropped; the controller's spacing between
  // swap and enable keeps this from happening in normal use.
  assign wr_go = wr_tick & q.pin_s2[PIN_WEA] & q.pin_s2[PIN_WEB]
                 & (q.waddr < FILLED) & ~swap_go;

  // Clear beats read, so a clear tied to read enable never loses a byte
  assign rd_go = rd_tick & q.pin_s2[PIN_REN] & (q.raddr < FILLED)
                 & ~clear_now;

  // Bank read port; address checked before use
  assign mem_rd = (q.raddr < FILLED) ? mem[q.bank][q.raddr] : '0;

  // Next-state logic for the whole control record
  always_comb begin
    d = q;
    d.pin_s1 = pins;
    d.pin_s2 = q.pin_s1;
    d.prev   = {q.pin_s2[PIN_CLR], q.pin_s2[PIN_RCLK], q.pin_s2[PIN_WCLK]};

    // Input holding latch follows every write clock rise
    if (wr_tick) begin
      d.hold = q.pin_s2[PIN_DATA +: DATA_W];
    end

    // Swap lock re-arms once the swap pin returns high
    if (q.pin_s2[PIN_SWAP]) begin
      d.swap_done = 1'b0;
    end
    if (swap_go) begin
      d.swap_done = 1'b1;
      d.bank      = ~q.bank;
    end

    // Pending clear: a new edge in the consuming cycle is kept
    if (clear_now) begin
      d.clr_pend = 1'b0;
    end
    if (clr_fall) begin
      d.clr_pend = 1'b1;
    end

    // Write address counter, saturating at the filled mark
    if (swap_go) begin
      d.waddr = '0;
    end else if (wr_go) begin
      d.waddr = q.waddr + ADDR_W'(1);
    end
    d.wfull = (d.waddr >= LAST_POS);

    // Read address counter and the two-stage output pipeline
    if (clear_now) begin
      d.raddr = '0;
    end else if (rd_go) begin
      d.raddr = q.raddr + ADDR_W'(1);
    end
    if (rd_go) begin
      d.pipe = mem_rd;
    end
    if (rd_tick) begin
      d.out = q.pipe;
    end
    d.rend = (d.raddr >= LAST_POS);

    // Count read clocks after the end flag rose, then release the pins
    if (clear_now) begin
      d.float_cnt = 2'h0;
    end else if (rd_tick && q.rend && q.float_cnt != FLOAT_TICKS) begin
      d.float_cnt = q.float_cnt + 2'h1;
    end
    d.oe_n_out = q.pin_s2[PIN_OE] | (d.float_cnt == FLOAT_TICKS);
  end

  // State register; synchronous reset keeps the whole record on one clock.
  // Reset leaves bank 0 for reading and bank 1 for writing.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Bank RAM; no reset, contents are undefined until written.
  // The held byte goes in, so each stored byte is the one latched one
  // write clock earlier.
  always_ff @(posedge clk) begin
    if (wr_go) begin
      mem[~q.bank][q.waddr] <= q.hold;
    end
  end

  // Outputs straight from the state register
  assign char_out      = q.out;
  assign char_out_oe_n = q.oe_n_out;
  assign wr_full_flag  = q.wfull;
  assign rd_end_flag   = q.rend;

  // Checks on the control record
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_write_other_bank: assert property (wr_go |-> !swap_go && q.waddr < FILLED)
    else $error("write outside the write bank");

  a_hold_capture: assert property (
    wr_tick |=> q.hold == $past(q.pin_s2[PIN_DATA +: DATA_W]))
    else $error("input byte not latched on write clock");

  a_write_advance: assert property (
    wr_go |=> q.waddr == $past(q.waddr) + 8'h01 && q.wfull == (q.waddr >= LAST_POS))
    else $error("write address did not advance");

  a_write_blocked: assert property (
    (!q.pin_s2[PIN_WEA] || !q.pin_s2[PIN_WEB] || q.waddr == FILLED) && !swap_go
    |=> q.waddr == $past(q.waddr))
    else $error("write address moved while blocked");

  a_swap_banks: assert property (
    swap_go |=> q.bank != $past(q.bank) && q.waddr == '0 && q.raddr == '0)
    else $error("swap did not zero counters and flip banks");

  a_read_latch: assert property (rd_go |=> q.pipe == $past(mem_rd))
    else $error("read byte not loaded into pipeline");

  a_read_advance: assert property (rd_go |=> q.raddr == $past(q.raddr) + 8'h01)
    else $error("read address did not advance");

  a_clear_edge: assert property (
    clr_fall ##1 (!rd_tick)[*2] ##1 rd_tick |=> q.raddr == '0)
    else $error("clear edge did not reset read address");

  a_pipe_stage: assert property (rd_tick |=> q.out == $past(q.pipe))
    else $error("output latch skipped pipeline stage");

  a_end_blocks: assert property (q.raddr == FILLED |-> !rd_go)
    else $error("read past the last position");

  a_float_after: assert property (q.float_cnt == FLOAT_TICKS |-> q.oe_n_out)
    else $error("data pins still driven after end of row");

  a_oe_follow: assert property (
    q.pin_s2[PIN_OE] |=> q.oe_n_out)
    else $error("data pins driven while output enable high");

  a_addr_saturate: assert property (q.waddr <= FILLED && q.raddr <= FILLED)
    else $error("address counter passed the filled mark");

  // Flags against the counters they report; chaining relies on them
  a_full_flag: assert property (
    q.waddr == FILLED |-> q.wfull)
    else $error("write flag low on a filled bank");

  a_end_flag: assert property (
    q.raddr == FILLED |-> q.rend)
    else $error("read flag low at end of row");

  a_full_block: assert property (
    q.wfull && q.waddr == FILLED |-> !wr_go)
    else $error("write into a filled bank");

  // Clear and swap handling on the read side
  a_clear_first: assert property (
    clear_now |-> !rd_go)
    else $error("read taken in a clearing tick");

  a_clear_pends: assert property (
    clr_fall |=> q.clr_pend)
    else $error("clear edge not remembered");

  a_swap_lock: assert property (
    swap_go |=> q.swap_done)
    else $error("swap lock not set after swap");

  a_bank_steady: assert property (
    !swap_go |=> q.bank == $past(q.bank))
    else $error("bank roles changed without swap");

  // Output latch and read address hold between read ticks; float clear and pin drive
  a_out_steady: assert property (
    !rd_tick |=> q.out == $past(q.out))
    else $error("output latch moved between read clocks");

  a_read_steady: assert property (
    !rd_go && !clear_now |=> q.raddr == $past(q.raddr))
    else $error("read address moved without a read");

  a_float_clear: assert property (
    clear_now |=> q.float_cnt == 2'h0)
    else $error("float count kept across a clear");

  a_oe_driven: assert property (
    !q.pin_s2[PIN_OE] && !q.rend |=> !q.oe_n_out)
    else $error("data pins released while enabled");


  c_bank_swap: cover property (swap_go ##1 wr_go);
  c_row_full: cover property (wr_go && q.waddr == LAST_POS);
  c_row_end: cover property (rd_go && q.raddr == LAST_POS);
  c_pins_float: cover property ($rose(q.oe_n_out) && q.rend);
  c_restart: cover property (clr_fall ##[1:40] clear_now);

endmodule

// >>> dv/rbf_pin_model.sv
/*
  Far-side pin clock model: the controller's write and read clocks.
  Assumes clk runs far faster than the pin clocks; each phase lasts
  at least six clk periods, above the four the buffer needs to see an edge.
*/
`timescale 1ns/100ps

module rbf_pin_model (
  input  wire logic clk,
  output logic      wr_clk_pin,
  output logic      rd_clk_pin
);
  // Clocks stand low between ticks, as the controller gates them
  initial begin
    wr_clk_pin = 1'b0;
    rd_clk_pin = 1'b0;
  end

  // One full write clock period, rising edge first
  task automatic wtick();
    @(posedge clk);
    wr_clk_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wr_clk_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // One full read clock period, rising edge first
  task automatic rtick();
    @(posedge clk);
    rd_clk_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd_clk_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> dv/dual_row_video_buffer_bench.sv
/*
  Self-checking bench of the dual row character buffer.
  Assumes the pin model supplies the pin clocks; all else is driven here.
*/
`timescale 1ns/100ps

module dual_row_video_buffer_bench;
  import rbf_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              wr_clk_pin;
  logic              rd_clk_pin;
  logic [DATA_W-1:0] char_in = 8'h00;
  logic              wr_en = 1'b0;
  logic              wr_en_b = 1'b1;
  logic              row_swap_n = 1'b1;
  logic              rd_en = 1'b0;
  logic              out_enable_n = 1'b0;
  logic [DATA_W-1:0] char_out;
  logic              char_out_oe_n;
  logic              wr_full_flag;
  logic              rd_end_flag;
  int                miscompares = 0;
  int                checks = 0;

  always #10 clk = ~clk;

  rbf_pin_model rbf_pin_model_i (.clk(clk), .wr_clk_pin(wr_clk_pin), .rd_clk_pin(rd_clk_pin));

  // Clear tied to read enable, as a controller may wire it
  rbf_row_buffer rbf_row_buffer_i (
    .clk(clk), .sys_rst(sys_rst), .wr_clk_pin(wr_clk_pin), .rd_clk_pin(rd_clk_pin),
    .char_in(char_in), .wr_enable_a(wr_en), .wr_enable_b(wr_en & wr_en_b),
    .row_swap_n(row_swap_n), .addr_clear_n(rd_en), .rd_enable(rd_en),
    .out_enable_n(out_enable_n), .char_out(char_out), .char_out_oe_n(char_out_oe_n),
    .wr_full_flag(wr_full_flag), .rd_end_flag(rd_end_flag));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Load n bytes s, s+1, ...; a latch-only tick first keeps enable spacing
  task automatic fill(input int n, input logic [7:0] s);
    char_in <= s;
    rbf_pin_model_i.wtick();
    wr_en <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      char_in <= s + 8'(i);
      rbf_pin_model_i.wtick();
      chk({7'h00, wr_full_flag}, {7'h00, i >= 134});
    end
    wr_en <= 1'b0;
    rbf_pin_model_i.wtick();
  endtask

  // Swap banks: both swap and clear low over one read clock
  task automatic swap_rows();
    row_swap_n <= 1'b0;
    rbf_pin_model_i.rtick();
    row_swap_n <= 1'b1;
  endtask

  // Play n bytes out; data trails the bank read by one read clock
  task automatic drain(input int n, input logic [7:0] s);
    rd_en <= 1'b1;
    for (int k = 1; k <= n + 1; k++) begin
      rbf_pin_model_i.rtick();
      if (k >= 2) chk(char_out, s + 8'(k - 2));
      if (k <= n) chk({7'h00, rd_end_flag}, {7'h00, k >= 134});
      if (k == n) chk({7'h00, char_out_oe_n}, 8'h00);
    end
  endtask

  // Full row: flags at the last position, then the pins float
  task automatic full_row();
    fill(BANK_DEPTH, 8'h20);
    swap_rows();
    drain(BANK_DEPTH, 8'h20);
    rbf_pin_model_i.rtick();
    chk({7'h00, char_out_oe_n}, 8'h01);
    rd_en <= 1'b0;
  endtask

  // Clear falling edge restarts the same row and drives the pins again
  task automatic restart_row();
    rbf_pin_model_i.rtick();
    rbf_pin_model_i.rtick();
    drain(4, 8'h20);
    rd_en <= 1'b0;
    out_enable_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h00, char_out_oe_n}, 8'h01);
    out_enable_n <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // One enable low: nothing stored, so the next row still starts at slot 0
  task automatic blocked_writes();
    char_in <= 8'hee;
    wr_en   <= 1'b1;
    wr_en_b <= 1'b0;
    repeat (3) rbf_pin_model_i.wtick();
    chk({7'h00, wr_full_flag}, 8'h00);
    wr_en   <= 1'b0;
    wr_en_b <= 1'b1;
    rbf_pin_model_i.wtick();
  endtask

  // Short second row in the other bank, then swapped in
  task automatic short_row();
    fill(10, 8'h90);
    swap_rows();
    drain(10, 8'h90);
    rd_en <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    full_row();
    restart_row();
    blocked_writes();
    short_row();
    give_verdict();
  end

  // Watchdog far beyond the few thousand clocks the tests take
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
